//--- include/ecs_pkg.sv
// layout constants and carrier types for the enclave control structure checker
// assumes the structure is presented as a flat 4 KB image by the fetch logic
package ecs_pkg;
    // structure geometry
    localparam int unsigned ECS_BYTES          = 4096;
    localparam int unsigned ECS_ALIGN_BITS     = 12;      // 4 KB alignment
    // byte offsets of fields
    localparam int unsigned OFF_SIZE           = 0;
    localparam int unsigned OFF_BASE           = 8;
    localparam int unsigned OFF_FRAME_PAGES    = 16;
    localparam int unsigned OFF_INFO_SELECT    = 20;
    localparam int unsigned OFF_RSVD_A         = 24;
    localparam int unsigned LEN_RSVD_A         = 24;
    localparam int unsigned OFF_ATTR           = 48;
    localparam int unsigned OFF_BUILD_MEAS     = 64;
    localparam int unsigned OFF_RSVD_B         = 96;
    localparam int unsigned LEN_RSVD_B         = 32;
    localparam int unsigned OFF_SIGNER_MEAS    = 128;
    localparam int unsigned OFF_RSVD_C         = 160;
    localparam int unsigned LEN_RSVD_C         = 96;
    localparam int unsigned OFF_PRODUCT_ID     = 256;
    localparam int unsigned OFF_SEC_VERSION    = 258;
    localparam int unsigned OFF_TAIL           = 260;
    localparam int unsigned LEN_TAIL           = 3836;
    // device-chosen locations inside the tail
    localparam int unsigned OFF_ENCLAVE_ID     = 260;
    localparam int unsigned LEN_ENCLAVE_ID     = 8;
    localparam int unsigned OFF_KEY_PAD        = 268;
    localparam int unsigned LEN_KEY_PAD        = 352;
    // attribute bit positions
    localparam int unsigned ATTR_INIT_BIT      = 0;
    localparam int unsigned ATTR_DEBUG_BIT     = 1;
    localparam int unsigned ATTR_WIDE_BIT      = 2;
    localparam int unsigned ATTR_PROV_BIT      = 4;
    localparam int unsigned ATTR_TOKEN_BIT     = 5;
    localparam logic [63:0] ATTR_RSVD_MASK     = 64'hffff_ffff_ffff_ffc8;
    // selection vector
    localparam int unsigned SEL_FAULT_INFO_BIT = 0;
    localparam logic [31:0] SEL_RSVD_MASK      = 32'hffff_fffe;
    // check result codes
    typedef enum logic [2:0] {
        ECS_OK, ECS_ERR_ALIGN, ECS_ERR_SIZE, ECS_ERR_BASE,
        ECS_ERR_RSVD, ECS_ERR_ATTR, ECS_ERR_SELECT, ECS_ERR_INIT
    } ecs_err_type;
    // decoded attributes
    typedef struct packed {
        logic [63:0] feature_request_mask;
        logic        init_token_key_flag;
        logic        provisioning_key_flag;
        logic        wide_mode_flag;
        logic        debug_flag;
        logic        initialized;
    } ecs_attr_type;
    // decoded header fields
    typedef struct packed {
        logic [63:0] size;
        logic [63:0] enclave_base_linear_address;
        logic [31:0] save_frame_page_count;
        logic [31:0] extended_info_select_vector;
        logic [15:0] product_identifier;
        logic [15:0] security_version_number;
        logic [63:0] enclave_identifier;
    } ecs_hdr_type;
endpackage

//--- tb/ecs_layout_check_asserts.sv
// concurrent checks on the ports of the enclave control structure checker
// assumes one clock domain and a bind onto every ecs_layout_check instance
`timescale 1ns/1ps
module ecs_layout_check_asserts (
    // clock and reset
    input wire logic                             core_clk_in,
    input wire logic                             resetn_in,
    // requests
    input wire logic [ecs_pkg::ECS_BYTES*8-1:0] image_in,
    input wire logic [63:0]                      image_addr_in,
    input wire logic                             check_start_in,
    input wire logic                             exit_event_in,
    input wire logic [31:0]                      fault_info_in,
    // results
    input wire logic                             done_out,
    input wire logic                             prot_fault_out,
    input wire ecs_pkg::ecs_err_type             err_code_out,
    input wire ecs_pkg::ecs_hdr_type             hdr_out,
    input wire ecs_pkg::ecs_attr_type            attr_out,
    input wire logic                             debug_access_ok_out,
    input wire logic                             wide_mode_out,
    input wire logic [31:0]                      misc_support_out,
    input wire logic                             frame_info_we_out,
    input wire logic [31:0]                      frame_info_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // size field of the presented image and its power-of-two test
    wire logic [63:0] sz_w  = image_in[63:0];
    wire logic        pow_w = (sz_w != 64'h0) && ((sz_w & (sz_w - 64'h1)) == 64'h0);
    property p_done_next; check_start_in |=> done_out; endproperty
    a_done_next: assert property (p_done_next) else $error("no done after start");
    property p_done_cause; done_out |-> $past(check_start_in); endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without start");
    property p_code; done_out |-> prot_fault_out == (err_code_out != ecs_pkg::ECS_OK); endproperty
    a_code: assert property (p_code) else $error("fault and code disagree");
    property p_align; check_start_in && image_addr_in[11:0] != 12'h0 |=> err_code_out == ecs_pkg::ECS_ERR_ALIGN; endproperty
    a_align: assert property (p_align) else $error("misaligned structure accepted");
    property p_size; check_start_in && !pow_w |=> prot_fault_out; endproperty
    a_size: assert property (p_size) else $error("bad size accepted");
    property p_attr; check_start_in && (image_in[48*8+:64] & ecs_pkg::ATTR_RSVD_MASK) != 64'h0 |=> prot_fault_out; endproperty
    a_attr: assert property (p_attr) else $error("reserved attribute accepted");
    property p_sel; check_start_in && image_in[20*8+1+:31] != 31'h0 |=> prot_fault_out; endproperty
    a_sel: assert property (p_sel) else $error("reserved select bit accepted");
    property p_held; prot_fault_out |-> hdr_out == $past(hdr_out); endproperty
    a_held: assert property (p_held) else $error("held header changed on fault");
    property p_perm; {debug_access_ok_out, wide_mode_out} == $past({attr_out.debug_flag, attr_out.wide_mode_flag}); endproperty
    a_perm: assert property (p_perm) else $error("permission outputs lag wrong");
    property p_frame; exit_event_in && misc_support_out != 32'h0 && hdr_out.extended_info_select_vector[0]
        |=> frame_info_we_out && frame_info_out == $past(fault_info_in); endproperty
    a_frame: assert property (p_frame) else $error("selected info not saved");
endmodule
bind ecs_layout_check ecs_layout_check_asserts u_asserts (.*);

//--- tb/ecs_layout_check_tb.sv
// self-checking bench for the enclave control structure checker
// assumes the design answers one cycle after each start strobe
`timescale 1ns/1ps
module ecs_layout_check_tb;
    logic                 core_clk_in, resetn_in, start, create, init, report, exit_ev;
    logic [32767:0]       image, good;       // driven image and the one to send next
    logic [63:0]          addr;
    logic [31:0]          finfo, misc, fdata;
    logic                 done, fault, dbg, wide, prov, tok, we;
    logic [127:0]         perm;
    logic [255:0]         bm, sm;            // build and signer measurements
    logic [2815:0]        kpad;              // held key padding pattern
    ecs_pkg::ecs_err_type err;
    ecs_pkg::ecs_hdr_type hdr;
    ecs_pkg::ecs_attr_type attr;
    int                   n_errors = 0;
    int                   checks = 0;
    ecs_layout_check dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .image_in(image), .image_addr_in(addr),
        .check_start_in(start), .create_mode_in(create), .initialize_in(init), .report_mode_in(report),
        .exit_event_in(exit_ev), .fault_info_in(finfo), .done_out(done), .prot_fault_out(fault), .err_code_out(err),
        .hdr_out(hdr), .attr_out(attr), .build_meas_out(bm), .signer_meas_out(sm), .key_pad_out(kpad),
        .debug_access_ok_out(dbg), .wide_mode_out(wide), .prov_key_ok_out(prov), .token_key_ok_out(tok),
        .permitted_attr_out(perm), .misc_support_out(misc), .frame_info_we_out(we), .frame_info_out(fdata));
    // a structure that passes every check in create mode
    function automatic logic [32767:0] mk();
        logic [32767:0] m;
        m = '0;
        m[0+:64] = 64'h0000_0000_0010_0000;
        m[64+:64] = 64'h0000_0000_4000_0000;
        m[128+:32] = 32'h0000_0001;
        m[160+:32] = 32'h0000_0001;
        m[384+:128] = {64'h0000_0000_0000_0003, 64'h0000_0000_0000_0016};
        m[512+:256] = {4{64'h0123_4567_89ab_cdef}};
        m[1024+:256] = {4{64'hfedc_ba98_7654_3210}};
        m[2048+:32] = {16'h0005, 16'h1234};
        return m;
    endfunction
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one start strobe; returns just after the answering edge
    task automatic run(input logic [63:0] a, input logic c, input logic r);
        @(posedge core_clk_in);
        image <= good;
        addr <= a;
        create <= c;
        report <= r;
        start <= 1'b1;
        @(posedge core_clk_in);
        start <= 1'b0;
        #1;
    endtask
    task automatic t_good();
        good = mk();
        run(64'h0000_0000_0000_3000, 1'b1, 1'b0);
        cmp({done, fault, 3'(err)}, {2'b10, 3'(ecs_pkg::ECS_OK)});
        cmp({hdr.size, hdr.enclave_base_linear_address}, {64'h10_0000, 64'h4000_0000});
        cmp({hdr.save_frame_page_count, hdr.extended_info_select_vector}, 64'h1_0000_0001);
        cmp({hdr.product_identifier, hdr.security_version_number}, 32'h1234_0005);
        cmp(attr, {64'h3, 5'b01110});
        cmp(bm[127:0], {2{64'h0123_4567_89ab_cdef}});
        cmp(bm[255:128], {2{64'h0123_4567_89ab_cdef}});
        cmp(sm[127:0], {2{64'hfedc_ba98_7654_3210}});
        cmp(sm[255:128], {2{64'hfedc_ba98_7654_3210}});
        cmp({hdr.enclave_identifier, kpad[63:0]}, 128'h0);
        @(posedge core_clk_in);
        #1;
        cmp({dbg, wide, prov, tok}, 4'b1110);
        cmp({perm, misc}, {128'hffff_ffff_ffff_ffff_0000_0000_0000_0037, 32'h1});
        @(posedge core_clk_in);
        init <= 1'b1;
        @(posedge core_clk_in);
        init <= 1'b0;
        #1;
        cmp(attr.initialized, 1'b1);
        $display("test good done");
    endtask
    // each case breaks one constraint; held fields must not move
    task automatic t_bad();
        logic [2:0] exp;
        for (int i = 0; i < 10; i++) begin
            good = mk();
            good[2048+:16] = 16'h9999;
            case (i)
                0: exp = 3'(ecs_pkg::ECS_ERR_ALIGN);
                1: begin good[0+:64] = 64'h3; exp = 3'(ecs_pkg::ECS_ERR_SIZE); end
                2: begin good[0+:64] = 64'h0; exp = 3'(ecs_pkg::ECS_ERR_SIZE); end
                3: begin good[64+:64] = 64'h4000_1000; exp = 3'(ecs_pkg::ECS_ERR_BASE); end
                4: begin good[240+:8] = 8'h01; exp = 3'(ecs_pkg::ECS_ERR_RSVD); end
                5: begin good[24000+:8] = 8'h01; exp = 3'(ecs_pkg::ECS_ERR_RSVD); end
                6: begin good[387] = 1'b1; exp = 3'(ecs_pkg::ECS_ERR_ATTR); end
                7: begin good[161] = 1'b1; exp = 3'(ecs_pkg::ECS_ERR_SELECT); end
                default: begin good[384] = (i == 8); exp = 3'(ecs_pkg::ECS_ERR_INIT); end
            endcase
            run((i == 0) ? 64'h3010 : 64'h3000, i != 9, i == 9);
            cmp({fault, 3'(err), hdr.product_identifier}, {1'b1, exp, 16'h1234});
        end
        $display("test bad done");
    endtask
    task automatic t_exit();
        @(posedge core_clk_in);
        exit_ev <= 1'b1;
        finfo <= 32'hcafe_0001;
        @(posedge core_clk_in);
        exit_ev <= 1'b0;
        #1;
        cmp({we, fdata}, {1'b1, 32'hcafe_0001});
        $display("test exit done");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // a hang is cut short well beyond the few dozen cycles needed
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial begin
        {resetn_in, start, create, init, report, exit_ev} = 6'h0;
        image = '0;
        good = '0;
        addr = 64'h0;
        finfo = 32'h0;
        repeat (3) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        t_good();
        t_bad();
        t_exit();
        stop_test();
    end
endmodule

//--- verilog/ecs_layout_check.sv
// enclave control structure decoder and validity checker
// assumes the fetch logic presents the whole structure image with its address
// and a one-cycle start strobe; the image stays stable until done is seen
`timescale 1ns/1ps
module ecs_layout_check #(
    parameter logic [127:0] PERMITTED_ATTR = 128'hffff_ffff_ffff_ffff_0000_0000_0000_0037,
    parameter logic [31:0]  MISC_SUPPORT   = 32'h0000_0001
) (
    // clock and reset
    input  wire logic                         core_clk_in,
    input  wire logic                         resetn_in,
    // structure image and request
    input  wire logic [ecs_pkg::ECS_BYTES*8-1:0] image_in,
    input  wire logic [63:0]                  image_addr_in,
    input  wire logic                         check_start_in,   // one-cycle strobe
    input  wire logic                         create_mode_in,   // checking for creation
    input  wire logic                         initialize_in,    // initialize request on held structure
    input  wire logic                         report_mode_in,   // image is a report target
    input  wire logic                         exit_event_in,    // exit pulse, sampled on the clock without a synchronizer
    input  wire logic [31:0]                  fault_info_in,    // fault record for the frame
    // results
    output logic                              done_out,
    output logic                              prot_fault_out,
    output ecs_pkg::ecs_err_type              err_code_out,
    output ecs_pkg::ecs_hdr_type              hdr_out,
    output ecs_pkg::ecs_attr_type             attr_out,
    output logic [255:0]                      build_meas_out,
    output logic [255:0]                      signer_meas_out,
    output logic [ecs_pkg::LEN_KEY_PAD*8-1:0] key_pad_out,
    // derived permissions
    output logic                              debug_access_ok_out,
    output logic                              wide_mode_out,
    output logic                              prov_key_ok_out,
    output logic                              token_key_ok_out,
    // capability query and frame write
    output logic [127:0]                      permitted_attr_out,
    output logic [31:0]                       misc_support_out,
    output logic                              frame_info_we_out,
    output logic [31:0]                       frame_info_out
);
    // overview of operation
    // the fetch logic hands over the whole structure page as one flat word,
    // byte k of the page at bits 8k+7 down to 8k, multi-byte fields little
    // endian; the page address comes along so that placement can be judged
    // a check is started by a one-cycle strobe; every check finishes in a
    // single cycle, so done, fault and the error code appear on the edge
    // that follows the strobe and no busy flag is needed
    // back-to-back strobes are legal: each one is judged on its own image
    // the image and the mode levels are sampled only with the strobe; they
    // may change freely between checks
    // a failed check raises the fault pulse and reports why in the code;
    // all held fields keep what the last passing check or initialize loaded, so a bad
    // structure can never overwrite the state of a good one
    // the error code is held from one check to the next, while done and
    // fault are pulses of one cycle each
    // the permission outputs follow the held attributes one cycle later;
    // they are registered again to keep every output straight from a flop
    // limitation: the whole page is decoded in one cycle; the reserved-byte
    // reduction over the tail is a wide or-tree, which was traded against
    // the latency and area of a byte-serial scan
    // limitation: the reserved gaps are judged whatever the mode, the tail
    // only when creating or reporting, since software clears it just then
    // the identifier and key pad live inside the tail at fixed spots picked
    // for this device; they read back as zero after a creation check
    // the capability outputs are plain copies of the parameters, so the
    // permitted-attribute bitmap and the misc support value can be tuned
    // per product without touching the logic
    // the exit path writes the fault record into the frame only when the
    // device supports extended info and the held vector selects it
    // initialize sets the held initialized flag; a passing check in the
    // same cycle wins, since it reloads the whole attribute set
    // reset clears every output; a start may come at the first edge after
    // reset is released

    // byte-field extract from the flat image
    function automatic logic [63:0] fld64(input int unsigned off);
        fld64 = image_in[off*8 +: 64];
    endfunction

    // combinational decode of the incoming image
    logic [63:0]  size_w;           // enclave size
    logic [63:0]  base_w;           // base linear address
    logic [127:0] attr_w;           // raw attributes
    logic [31:0]  sel_w;            // selection vector
    logic         rsvd_nz_w;        // any reserved byte nonzero
    logic         tail_nz_w;        // tail nonzero
    ecs_pkg::ecs_err_type err_w;    // first failing check

    assign size_w = fld64(ecs_pkg::OFF_SIZE);
    assign base_w = fld64(ecs_pkg::OFF_BASE);
    assign sel_w  = image_in[ecs_pkg::OFF_INFO_SELECT*8 +: 32];
    assign attr_w = image_in[ecs_pkg::OFF_ATTR*8 +: 128];
    // reserved gaps between fields must be clear
    assign rsvd_nz_w = (|image_in[ecs_pkg::OFF_RSVD_A*8 +: ecs_pkg::LEN_RSVD_A*8])
                     | (|image_in[ecs_pkg::OFF_RSVD_B*8 +: ecs_pkg::LEN_RSVD_B*8])
                     | (|image_in[ecs_pkg::OFF_RSVD_C*8 +: ecs_pkg::LEN_RSVD_C*8]);
    // tail clearing is software's duty; checked only where it is required
    assign tail_nz_w = |image_in[ecs_pkg::OFF_TAIL*8 +: ecs_pkg::LEN_TAIL*8];

    // priority-ordered validity checks
    // only the first failing check is reported, in this order:
    //   placement of the page
    //   size zero or not a power of two
    //   base not aligned to the size
    //   reserved gaps, and the tail where it must be clear
    //   reserved or unpermitted attribute bits
    //   reserved selection bits, or any selection without misc support
    //   initialized flag wrong for the requested operation
    // the order matters: the base test uses size-1 as a mask, which is only
    // meaningful once the size is known to be a power of two
    // a zero size is refused first, so size-1 never wraps into a full mask
    // the attribute test covers both the fixed reserved mask and the
    // per-product permitted bitmap; either one failing refuses the page
    // the select test also refuses a nonzero vector when the device has no
    // misc support, so such a vector never reaches the held header
    // creation needs the initialized flag clear; a report target needs it
    // set, as the target must describe an already initialized enclave
    // everything here is combinational and is only looked at together
    // with the start strobe, so glitches on the image do no harm
    always_comb begin
        err_w = ecs_pkg::ECS_OK;
        if (|image_addr_in[ecs_pkg::ECS_ALIGN_BITS-1:0]) begin
            err_w = ecs_pkg::ECS_ERR_ALIGN;
        end else if (size_w == 64'h0 || (size_w & (size_w - 64'h1)) != 64'h0) begin
            err_w = ecs_pkg::ECS_ERR_SIZE;
        end else if ((base_w & (size_w - 64'h1)) != 64'h0) begin
            err_w = ecs_pkg::ECS_ERR_BASE;
        end else if (rsvd_nz_w || ((create_mode_in || report_mode_in) && tail_nz_w)) begin
            err_w = ecs_pkg::ECS_ERR_RSVD;
        end else if ((attr_w[63:0] & ecs_pkg::ATTR_RSVD_MASK) != 64'h0
                     || (attr_w & ~PERMITTED_ATTR) != 128'h0) begin
            err_w = ecs_pkg::ECS_ERR_ATTR;
        end else if ((sel_w & ecs_pkg::SEL_RSVD_MASK) != 32'h0
                     || (MISC_SUPPORT == 32'h0 && sel_w != 32'h0)) begin
            err_w = ecs_pkg::ECS_ERR_SELECT;
        end else if (create_mode_in && attr_w[ecs_pkg::ATTR_INIT_BIT]) begin
            err_w = ecs_pkg::ECS_ERR_INIT;
        end else if (report_mode_in && !attr_w[ecs_pkg::ATTR_INIT_BIT]) begin
            err_w = ecs_pkg::ECS_ERR_INIT;
        end
    end

    // completion, fault and error code, one cycle after start
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out       <= 1'b0;
            prot_fault_out <= 1'b0;
            err_code_out   <= ecs_pkg::ECS_OK;
        end else begin
            done_out       <= check_start_in;
            prot_fault_out <= check_start_in && (err_w != ecs_pkg::ECS_OK);
            if (check_start_in) begin
                err_code_out <= err_w;
            end
        end
    end

    // held structure state; a failed check leaves it untouched
    // the header, the measurements and the key pad are loaded together so
    // that no consumer can ever see a mix of two different structures
    // nothing here is cleared by a failed check: the fault is reported and
    // the earlier enclave state stays exactly as it was
    // the key pad is wide; it is kept as a plain register here because the
    // key derivation logic wants all of it in one cycle
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hdr_out         <= '0;
            build_meas_out  <= '0;
            signer_meas_out <= '0;
            key_pad_out     <= '0;
        end else if (check_start_in && err_w == ecs_pkg::ECS_OK) begin
            hdr_out.size                        <= size_w;
            hdr_out.enclave_base_linear_address <= base_w;
            hdr_out.save_frame_page_count       <= image_in[ecs_pkg::OFF_FRAME_PAGES*8 +: 32];
            hdr_out.extended_info_select_vector <= sel_w;
            hdr_out.product_identifier          <= image_in[ecs_pkg::OFF_PRODUCT_ID*8 +: 16];
            hdr_out.security_version_number     <= image_in[ecs_pkg::OFF_SEC_VERSION*8 +: 16];
            hdr_out.enclave_identifier          <= fld64(ecs_pkg::OFF_ENCLAVE_ID);
            build_meas_out  <= image_in[ecs_pkg::OFF_BUILD_MEAS*8 +: 256];
            signer_meas_out <= image_in[ecs_pkg::OFF_SIGNER_MEAS*8 +: 256];
            key_pad_out     <= image_in[ecs_pkg::OFF_KEY_PAD*8 +: ecs_pkg::LEN_KEY_PAD*8];
        end
    end

    // attributes; initialize sets the initialized flag of the held structure
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            attr_out <= '0;
        end else if (check_start_in && err_w == ecs_pkg::ECS_OK) begin
            attr_out.initialized           <= attr_w[ecs_pkg::ATTR_INIT_BIT];
            attr_out.debug_flag            <= attr_w[ecs_pkg::ATTR_DEBUG_BIT];
            attr_out.wide_mode_flag        <= attr_w[ecs_pkg::ATTR_WIDE_BIT];
            attr_out.provisioning_key_flag <= attr_w[ecs_pkg::ATTR_PROV_BIT];
            attr_out.init_token_key_flag   <= attr_w[ecs_pkg::ATTR_TOKEN_BIT];
            attr_out.feature_request_mask  <= attr_w[127:64];
        end else if (initialize_in) begin
            attr_out.initialized <= 1'b1;
        end
    end

    // permissions derived from the held attributes
    // these feed the debugger access gate, the execution mode selection and
    // the key retrieval path; the extra register stage costs one cycle of
    // lag after a check, which those users tolerate
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            debug_access_ok_out <= 1'b0;
            wide_mode_out       <= 1'b0;
            prov_key_ok_out     <= 1'b0;
            token_key_ok_out    <= 1'b0;
        end else begin
            debug_access_ok_out <= attr_out.debug_flag;
            wide_mode_out       <= attr_out.wide_mode_flag;
            prov_key_ok_out     <= attr_out.provisioning_key_flag;
            token_key_ok_out    <= attr_out.init_token_key_flag;
        end
    end

    // capability report, constant after reset
    // these are registered copies of the parameters so that the query path
    // sees flops like every other output; they read zero during reset
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            permitted_attr_out <= '0;
            misc_support_out   <= '0;
        end else begin
            permitted_attr_out <= PERMITTED_ATTR;
            misc_support_out   <= MISC_SUPPORT;
        end
    end

    // frame write on exit: only the selected info, only with misc support
    // the write strobe is a pulse one cycle after the exit event; the data
    // is zero when the fault info is not selected, so an unselected frame
    // never carries stale fault details out of the enclave
    // the selection comes from the held header, i.e. the last passing check
    // hazard: an exit in the same cycle as a passing check still uses the
    // previous vector, as the new header lands on that same edge
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_info_we_out <= 1'b0;
            frame_info_out    <= '0;
        end else begin
            frame_info_we_out <= exit_event_in && (MISC_SUPPORT != 32'h0)
                                 && hdr_out.extended_info_select_vector[ecs_pkg::SEL_FAULT_INFO_BIT];
            if (exit_event_in) begin
                frame_info_out <= hdr_out.extended_info_select_vector[ecs_pkg::SEL_FAULT_INFO_BIT]
                                  ? fault_info_in : 32'h0;
            end
        end
    end
endmodule
